// file: logic/vpic_pkg.sv
`default_nettype none

package vpic_pkg;
  localparam int NSRC = 32;
  localparam int STACK_DEPTH = 8;
  localparam logic [31:0] BASE_ADDR = 32'hFFFF_F000;
  localparam logic [8:0] OFF_SMR = 9'h000;
  localparam logic [8:0] OFF_SVR = 9'h080;
  localparam logic [8:0] OFF_IVR = 9'h100;
  localparam logic [8:0] OFF_FVR = 9'h104;
  localparam logic [8:0] OFF_ISR = 9'h108;
  localparam logic [8:0] OFF_IPR = 9'h10C;
  localparam logic [8:0] OFF_IMR = 9'h110;
  localparam logic [8:0] OFF_CISR = 9'h114;
  localparam logic [8:0] OFF_IECR = 9'h120;
  localparam logic [8:0] OFF_IDCR = 9'h124;
  localparam logic [8:0] OFF_ICCR = 9'h128;
  localparam logic [8:0] OFF_ISCR = 9'h12C;
  localparam logic [8:0] OFF_EOICR = 9'h130;
  localparam logic [8:0] OFF_FFER = 9'h140;
  localparam logic [8:0] OFF_FFDR = 9'h144;
  localparam logic [8:0] OFF_FFSR = 9'h148;
  // Sources wired to pins; the rest are internal and active high
  localparam logic [31:0] EXT_MASK = 32'hC000_0001;
  localparam int SMR_PRIO_LSB = 0;
  localparam int SMR_TRIG_LSB = 5;
  localparam int CISR_FIQ_BIT = 0;
  localparam int CISR_IRQ_BIT = 1;
  localparam logic [1:0] TRIG_LOW_LVL = 2'h0;
  localparam logic [1:0] TRIG_FALL = 2'h1;
  localparam logic [1:0] TRIG_HIGH_LVL = 2'h2;
  localparam logic [1:0] TRIG_RISE = 2'h3;
  localparam logic [31:0] SVR_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] trig;
    logic [2:0] prio;
  } vpic_mode_s;

  typedef struct packed {
    logic [4:0] id;
    logic [2:0] prio;
  } vpic_frame_s;

  typedef enum logic {SVC_IDLE, SVC_BUSY} vpic_svc_e;
endpackage

`default_nettype wire

// file: logic/vpic_resolver.sv
`timescale 1ns/100ps
`default_nettype none

module vpic_resolver (
  input wire logic [31:0] cand,
  input wire vpic_pkg::vpic_mode_s [31:0] mode,
  output logic best_valid,
  output logic [4:0] best_id,
  output logic [2:0] best_prio
);
  // Ascending scan with strict compare keeps the lowest number on ties
  always_comb begin
    best_valid = 1'b0;
    best_id = 5'h00;
    best_prio = 3'h0;
    for (int i = 0; i < 32; i++) begin
      if (cand[i] && (!best_valid || mode[i].prio > best_prio)) begin
        best_valid = 1'b1;
        best_id = 5'(i);
        best_prio = mode[i].prio;
      end
    end
  end
endmodule

`default_nettype wire

// file: logic/vpic_src_stage.sv
`timescale 1ns/100ps
`default_nettype none

module vpic_src_stage #(
  parameter bit EXTERNAL = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic raw_in,
  input wire logic [1:0] trig,
  input wire logic set_cmd,
  input wire logic clr_cmd,
  input wire logic auto_clr,
  output logic active
);
  logic sync1_reg, sync2_reg, lvl_prev_reg, latch_reg;
  logic lvl, edge_mode;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Internal lines are always active high; pins follow the polarity bit
  assign lvl = (EXTERNAL && !trig[1]) ? ~sync2_reg : sync2_reg;
  assign edge_mode = trig[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_prev_reg <= 1'b0;
    end else begin
      lvl_prev_reg <= lvl;
    end
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_reg <= 1'b0;
    end else if (!edge_mode) begin
      latch_reg <= 1'b0;
    end else begin
      latch_reg <= (lvl & ~lvl_prev_reg) | set_cmd | (latch_reg & ~(clr_cmd | auto_clr));
    end
  end

  assign active = edge_mode ? latch_reg : lvl;
endmodule

`default_nettype wire

// file: logic/vpic_top.sv
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Internal sources individually choose level or edge detection.
// - External sources choose high level, low level, rising or falling edge.
// - Enable and disable commands change the mask in one write; mask readable.
// - A disabled source never affects priority, request or servicing of others.
// - Set command latches, clear command removes, pending of edge sources.
// - Set and clear commands leave level-sensitive sources untouched.
// - Vector read clears the latched edge of the chosen source only.
// - Vector read auto clear skips sources with fast forcing enabled.
// - Source 0 is auto cleared by fast vector reads, not normal ones.
// - Pending register shows raw detected activity regardless of mask.
// - Current-source register returns the current interrupt number.
// - Core status register mirrors both request outputs.
// - Normal request comes only from sources 1 to 31 without forcing.
// - Each source has a 3-bit priority, 7 most urgent.
// - Request asserts at once; choice of current interrupt waits for vector read.
// - Vector read starts service and sets current level to chosen priority.
// - Equal top priorities resolve to the smallest source number.
// - While servicing, request reasserts only for strictly higher priority.
// - Nested vector read pushes number and level; end-of-interrupt pops.
// - Nesting stack holds eight entries.
// - Vector read returns the stored handler address of the chosen source.
// - Vector register sits at absolute address FFFF_F100.
// - Vector read deasserts the normal request.
// - Fast vector read returns the handler address of source 0.
module vpic_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [31:0] irq_src,
  output logic normal_request_n,
  output logic fast_request_n
);
  vpic_pkg::vpic_mode_s [31:0] mode_reg;
  logic [31:0] svr_reg [32];
  logic [31:0] mask_reg, ffe_reg, hrdata_reg;
  logic dp_wr_reg, nreq_reg, nfast_reg;
  logic [8:0] dp_off_reg;
  vpic_pkg::vpic_svc_e svc_reg;
  logic [4:0] cur_id_reg;
  logic [2:0] cur_prio_reg;
  logic [3:0] sp_reg;
  vpic_pkg::vpic_frame_s stk [vpic_pkg::STACK_DEPTH];

  logic ap, hit, ivr_rd, fvr_rd, take, eoi, irq_want, fiq_want;
  logic best_valid, tie_ok;
  logic [4:0] best_id;
  logic [2:0] best_prio;
  logic [31:0] pend, cand, set_vec, clr_vec, en_vec, dis_vec;
  logic [31:0] ffen_vec, ffdis_vec, auto_vec, rd_mux;

  function automatic logic in_bank(input logic [8:0] off, input logic [8:0] bank);
    in_bank = (off[8:7] == bank[8:7]);
  endfunction

  function automatic logic [31:0] cmd_vec(input logic wr, input logic [8:0] off,
                                          input logic [8:0] reg_off, input logic [31:0] data);
    cmd_vec = (wr && off == reg_off) ? data : 32'h0000_0000;
  endfunction

  // Bus decode: only word-aligned accesses inside the block's window
  assign ap = hsel & htrans[1] & hready;
  assign hit = (haddr[31:9] == vpic_pkg::BASE_ADDR[31:9]) && (haddr[1:0] == 2'h0);
  assign ivr_rd = ap & ~hwrite & hit & (haddr[8:0] == vpic_pkg::OFF_IVR);
  assign fvr_rd = ap & ~hwrite & hit & (haddr[8:0] == vpic_pkg::OFF_FVR);
  assign eoi = dp_wr_reg && dp_off_reg == vpic_pkg::OFF_EOICR;

  // One wait state on end-of-interrupt keeps a vector read off the same edge as the pop
  assign hreadyout = ~eoi;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_off_reg <= 9'h000;
    end else begin
      dp_wr_reg <= ap & hwrite & hit;
      dp_off_reg <= haddr[8:0];
    end
  end

  assign set_vec = cmd_vec(dp_wr_reg, dp_off_reg, vpic_pkg::OFF_ISCR, hwdata);
  assign clr_vec = cmd_vec(dp_wr_reg, dp_off_reg, vpic_pkg::OFF_ICCR, hwdata);
  assign en_vec = cmd_vec(dp_wr_reg, dp_off_reg, vpic_pkg::OFF_IECR, hwdata);
  assign dis_vec = cmd_vec(dp_wr_reg, dp_off_reg, vpic_pkg::OFF_IDCR, hwdata);
  assign ffen_vec = cmd_vec(dp_wr_reg, dp_off_reg, vpic_pkg::OFF_FFER, hwdata);
  assign ffdis_vec = cmd_vec(dp_wr_reg, dp_off_reg, vpic_pkg::OFF_FFDR, hwdata);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= vpic_pkg::MASK_RST;
    end else begin
      mask_reg <= (mask_reg | en_vec) & ~dis_vec;
    end
  end

  // Source 0 is already the fast source, so its forcing bit stays zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ffe_reg <= vpic_pkg::MASK_RST;
    end else begin
      ffe_reg <= ((ffe_reg | ffen_vec) & ~ffdis_vec) & 32'hFFFF_FFFE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= '0;
    end else if (dp_wr_reg && in_bank(dp_off_reg, vpic_pkg::OFF_SMR)) begin
      mode_reg[dp_off_reg[6:2]].prio <= hwdata[vpic_pkg::SMR_PRIO_LSB +: 3];
      mode_reg[dp_off_reg[6:2]].trig <= hwdata[vpic_pkg::SMR_TRIG_LSB +: 2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 32; i++) begin
        svr_reg[i] <= vpic_pkg::SVR_RST;
      end
    end else if (dp_wr_reg && in_bank(dp_off_reg, vpic_pkg::OFF_SVR)) begin
      svr_reg[dp_off_reg[6:2]] <= hwdata;
    end
  end

  // Auto clear hits the chosen source, never a forced one, and source 0 on a fast vector read
  always_comb begin
    auto_vec = 32'h0000_0000;
    if (take && !ffe_reg[best_id]) begin
      auto_vec[best_id] = 1'b1;
    end
    auto_vec[0] = fvr_rd;
  end

  genvar g;
  generate
    for (g = 0; g < vpic_pkg::NSRC; g++) begin : g_src
      vpic_src_stage #(
        .EXTERNAL(vpic_pkg::EXT_MASK[g])
      ) u_src (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw_in(irq_src[g]),
        .trig(mode_reg[g].trig),
        .set_cmd(set_vec[g]),
        .clr_cmd(clr_vec[g]),
        .auto_clr(auto_vec[g]),
        .active(pend[g])
      );
    end
  endgenerate

  // Masked, forced and source 0 never reach the normal resolver
  assign cand = pend & mask_reg & ~ffe_reg & 32'hFFFF_FFFE;

  vpic_resolver u_res (
    .cand(cand),
    .mode(mode_reg),
    .best_valid(best_valid),
    .best_id(best_id),
    .best_prio(best_prio)
  );

  // Choice is frozen only at the vector read edge
  assign take = ivr_rd & best_valid;
  assign irq_want = best_valid && (svc_reg == vpic_pkg::SVC_IDLE || best_prio > cur_prio_reg);
  assign fiq_want = (pend[0] & mask_reg[0]) | (|(pend & mask_reg & ffe_reg));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nreq_reg <= 1'b1;
      nfast_reg <= 1'b1;
    end else begin
      nreq_reg <= ~(irq_want & ~take);
      nfast_reg <= ~fiq_want;
    end
  end

  assign normal_request_n = nreq_reg;
  assign fast_request_n = nfast_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      svc_reg <= vpic_pkg::SVC_IDLE;
      cur_id_reg <= 5'h00;
      cur_prio_reg <= 3'h0;
      sp_reg <= 4'h0;
    end else if (take) begin
      svc_reg <= vpic_pkg::SVC_BUSY;
      cur_id_reg <= best_id;
      cur_prio_reg <= best_prio;
      if (svc_reg == vpic_pkg::SVC_BUSY && sp_reg < 4'(vpic_pkg::STACK_DEPTH)) begin
        sp_reg <= sp_reg + 4'h1;
      end
    end else if (eoi) begin
      unique case (svc_reg)
        vpic_pkg::SVC_IDLE: begin
          sp_reg <= 4'h0;
        end
        vpic_pkg::SVC_BUSY: begin
          if (sp_reg != 4'h0) begin
            sp_reg <= sp_reg - 4'h1;
            cur_id_reg <= stk[3'(sp_reg - 4'h1)].id;
            cur_prio_reg <= stk[3'(sp_reg - 4'h1)].prio;
          end else begin
            svc_reg <= vpic_pkg::SVC_IDLE;
            cur_prio_reg <= 3'h0;
          end
        end
      endcase
    end
  end

  // Stack contents need no reset: the pointer guards every read
  always_ff @(posedge hclk) begin
    if (take && svc_reg == vpic_pkg::SVC_BUSY && sp_reg < 4'(vpic_pkg::STACK_DEPTH)) begin
      stk[3'(sp_reg)] <= '{id: cur_id_reg, prio: cur_prio_reg};
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_bank(haddr[8:0], vpic_pkg::OFF_SMR)) begin
      rd_mux[vpic_pkg::SMR_PRIO_LSB +: 3] = mode_reg[haddr[6:2]].prio;
      rd_mux[vpic_pkg::SMR_TRIG_LSB +: 2] = mode_reg[haddr[6:2]].trig;
    end else if (in_bank(haddr[8:0], vpic_pkg::OFF_SVR)) begin
      rd_mux = svr_reg[haddr[6:2]];
    end else begin
      unique case (haddr[8:0])
        vpic_pkg::OFF_IVR: rd_mux = best_valid ? svr_reg[best_id] : 32'h0000_0000;
        vpic_pkg::OFF_FVR: rd_mux = svr_reg[0];
        vpic_pkg::OFF_ISR: rd_mux = {27'h0, cur_id_reg};
        vpic_pkg::OFF_IPR: rd_mux = pend;
        vpic_pkg::OFF_IMR: rd_mux = mask_reg;
        vpic_pkg::OFF_FFSR: rd_mux = ffe_reg;
        vpic_pkg::OFF_CISR: begin
          rd_mux[vpic_pkg::CISR_FIQ_BIT] = ~nfast_reg;
          rd_mux[vpic_pkg::CISR_IRQ_BIT] = ~nreq_reg;
        end
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data is captured at the address edge, so the data phase needs no wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (ap && !hwrite && hit) begin
      hrdata_reg <= rd_mux;
    end else begin
      hrdata_reg <= 32'h0000_0000;
    end
  end

  // Helper for the tie check: no lower number may match or beat the winner
  always_comb begin
    tie_ok = 1'b1;
    for (int i = 0; i < 32; i++) begin
      if (best_valid && cand[i] && 5'(i) < best_id && mode_reg[i].prio >= best_prio) begin
        tie_ok = 1'b0;
      end
    end
  end

  mask_update_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (dp_wr_reg && dp_off_reg == vpic_pkg::OFF_IECR) |=> ((mask_reg & $past(hwdata)) == $past(hwdata)))
    else $error("enable command did not set mask bits");

  masked_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    best_valid |-> mask_reg[best_id])
    else $error("disabled source won priority");

  lowest_tie_a: assert property (@(posedge hclk) disable iff (!hresetn)
    best_valid |-> tie_ok)
    else $error("tie not resolved to smallest source");

  take_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take |=> (cur_prio_reg == $past(best_prio) && cur_id_reg == $past(best_id)
              && svc_reg == vpic_pkg::SVC_BUSY))
    else $error("vector read did not set current level");

  stack_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && svc_reg == vpic_pkg::SVC_BUSY && sp_reg < 4'h8) |=> sp_reg == $past(sp_reg) + 4'h1)
    else $error("nested vector read did not push");

  stack_pop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (eoi && sp_reg != 4'h0) |=> (sp_reg == $past(sp_reg) - 4'h1 && !hreadyout == 1'b0))
    else $error("end of interrupt did not pop");

  irq_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take |=> normal_request_n ##1 (normal_request_n || $past(best_prio > cur_prio_reg)))
    else $error("vector read left normal request asserted");

  nest_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (svc_reg == vpic_pkg::SVC_BUSY && best_prio <= cur_prio_reg) |=> normal_request_n)
    else $error("request raised for non-higher priority");

  no_fast_a: assert property (@(posedge hclk) disable iff (!hresetn)
    best_valid |-> (best_id != 5'h00 && !ffe_reg[best_id]))
    else $error("source 0 or forced source on normal path");

  auto_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $onehot0(auto_vec & 32'hFFFF_FFFE) && (ivr_rd || !(|(auto_vec & 32'hFFFF_FFFE))))
    else $error("auto clear touched more than the current source");

  cisr_image_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ap && !hwrite && hit && haddr[8:0] == vpic_pkg::OFF_CISR)
    |=> hrdata[vpic_pkg::CISR_IRQ_BIT] == ~$past(normal_request_n))
    else $error("core status does not mirror request");

  mask_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (dp_wr_reg && dp_off_reg == vpic_pkg::OFF_IDCR) |=> ((mask_reg & $past(hwdata)) == 32'h0000_0000))
    else $error("disable command did not clear mask bits");

  vector_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
    take |=> hrdata == $past(svr_reg[best_id]))
    else $error("vector read returned wrong handler address");

  fast_vector_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fvr_rd |=> hrdata == $past(svr_reg[0]))
    else $error("fast vector read returned wrong address");

  stack_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && svc_reg == vpic_pkg::SVC_BUSY && sp_reg < 4'h8)
    |=> (sp_reg <= 4'h8 && stk[3'(sp_reg - 4'h1)] == {$past(cur_id_reg), $past(cur_prio_reg)}))
    else $error("nested frame not saved on stack");
endmodule

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin \
  samples_checked++; \
  if ((got) !== (ex)) begin \
    err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
  end \
end

module tb_top;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic hreadyout;
  logic hresp;
  logic normal_request_n;
  logic fast_request_n;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] irq_src;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  vpic_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_src(irq_src), .normal_request_n(normal_request_n),
    .fast_request_n(fast_request_n));

  vpic_core_model u_core (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole run is a few hundred cycles; anything near this is a hang
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("[FAIL] run length expected below %0d seen %0d", 5000, cycles);
      close_out;
    end
  end

  task w(input logic [8:0] off, input logic [31:0] wd);
    logic [31:0] dummy;
    u_core.xfer(1'b1, off, wd, dummy);
  endtask

  task chk_rd(input string nm, input logic [8:0] off, input logic [31:0] ex);
    logic [31:0] d;
    u_core.xfer(1'b0, off, 32'h0000_0000, d);
    `CHK(nm, ex, d)
    `CHK("bus response", 1'b0, hresp)
  endtask

  task cfg(input int n, input logic [31:0] mode, input logic [31:0] vec);
    w(vpic_pkg::OFF_SMR + 9'(n * 4), mode);
    w(vpic_pkg::OFF_SVR + 9'(n * 4), vec);
  endtask

  task t_mask;
    chk_rd("mask after reset", vpic_pkg::OFF_IMR, vpic_pkg::MASK_RST);
    chk_rd("pending after reset", vpic_pkg::OFF_IPR, 32'h0000_0000);
    w(vpic_pkg::OFF_IECR, 32'h0000_00A5);
    w(vpic_pkg::OFF_IECR, 32'h8000_0000);
    chk_rd("mask enabled", vpic_pkg::OFF_IMR, 32'h8000_00A5);
    w(vpic_pkg::OFF_IDCR, 32'h8000_0021);
    chk_rd("mask disabled", vpic_pkg::OFF_IMR, 32'h0000_0084);
    w(vpic_pkg::OFF_IDCR, 32'hFFFF_FFFF);
    chk_rd("unmapped read", 9'h1FC, 32'h0000_0000);
    $display("t_mask finished");
  endtask

  task t_cmds;
    cfg(5, 32'h0000_0020, 32'h0000_0500);
    w(vpic_pkg::OFF_ISCR, 32'h0000_0060);
    repeat (2) @(posedge hclk);
    chk_rd("pending after set", vpic_pkg::OFF_IPR, 32'h0000_0020);
    `CHK("request while masked", 1'b1, normal_request_n)
    w(vpic_pkg::OFF_ICCR, 32'h0000_0020);
    chk_rd("pending after clear", vpic_pkg::OFF_IPR, 32'h0000_0000);
    irq_src[6] <= 1'b1;
    repeat (6) @(posedge hclk);
    w(vpic_pkg::OFF_ICCR, 32'h0000_0040);
    chk_rd("level kept", vpic_pkg::OFF_IPR, 32'h0000_0040);
    irq_src[6] <= 1'b0;
    repeat (6) @(posedge hclk);
    chk_rd("level gone", vpic_pkg::OFF_IPR, 32'h0000_0000);
    $display("t_cmds finished");
  endtask

  task t_prio;
    time t0;
    cfg(3, 32'h0000_0022, 32'h0000_0300);
    cfg(4, 32'h0000_0022, 32'h0000_0400);
    cfg(7, 32'h0000_0025, 32'h0000_0700);
    w(vpic_pkg::OFF_IECR, 32'h0000_0018);
    w(vpic_pkg::OFF_ISCR, 32'h0000_0098);
    repeat (4) @(posedge hclk);
    `CHK("request raised", 1'b0, normal_request_n)
    chk_rd("core status normal", vpic_pkg::OFF_CISR, 32'h0000_0002);
    chk_rd("vector equal prio", vpic_pkg::OFF_IVR, 32'h0000_0300);
    `CHK("request after read", 1'b1, normal_request_n)
    chk_rd("current source", vpic_pkg::OFF_ISR, 32'h0000_0003);
    chk_rd("auto clear", vpic_pkg::OFF_IPR, 32'h0000_0090);
    repeat (3) @(posedge hclk);
    `CHK("equal prio waits", 1'b1, normal_request_n)
    t0 = $time;
    u_core.eoi();
    // End-of-interrupt takes address, one wait state and the data cycle
    `CHK("eoi one wait state", 64'd120, $time - t0)
    repeat (3) @(posedge hclk);
    `CHK("request after eoi", 1'b0, normal_request_n)
    chk_rd("vector second", vpic_pkg::OFF_IVR, 32'h0000_0400);
    u_core.eoi();
    w(vpic_pkg::OFF_ICCR, 32'h0000_0080);
    w(vpic_pkg::OFF_IDCR, 32'hFFFF_FFFF);
    $display("t_prio finished");
  endtask

  task t_nest;
    cfg(8, 32'h0000_0021, 32'h0000_0800);
    cfg(9, 32'h0000_0026, 32'h0000_0900);
    w(vpic_pkg::OFF_IECR, 32'h0000_0300);
    w(vpic_pkg::OFF_ISCR, 32'h0000_0100);
    repeat (4) @(posedge hclk);
    chk_rd("vector low", vpic_pkg::OFF_IVR, 32'h0000_0800);
    w(vpic_pkg::OFF_ISCR, 32'h0000_0200);
    repeat (4) @(posedge hclk);
    `CHK("higher prio preempts", 1'b0, normal_request_n)
    chk_rd("vector nested", vpic_pkg::OFF_IVR, 32'h0000_0900);
    chk_rd("nested source", vpic_pkg::OFF_ISR, 32'h0000_0009);
    u_core.eoi();
    chk_rd("popped source", vpic_pkg::OFF_ISR, 32'h0000_0008);
    u_core.eoi();
    w(vpic_pkg::OFF_IDCR, 32'hFFFF_FFFF);
    $display("t_nest finished");
  endtask

  task t_fast;
    cfg(0, 32'h0000_0060, 32'h0000_0F00);
    w(vpic_pkg::OFF_IECR, 32'h0000_0001);
    w(vpic_pkg::OFF_ISCR, 32'h0000_0001);
    repeat (4) @(posedge hclk);
    `CHK("fast raised", 1'b0, fast_request_n)
    `CHK("normal quiet", 1'b1, normal_request_n)
    chk_rd("core status fast", vpic_pkg::OFF_CISR, 32'h0000_0001);
    chk_rd("vector no normal", vpic_pkg::OFF_IVR, 32'h0000_0000);
    chk_rd("source 0 kept", vpic_pkg::OFF_IPR, 32'h0000_0001);
    chk_rd("fast vector", vpic_pkg::OFF_FVR, 32'h0000_0F00);
    chk_rd("source 0 cleared", vpic_pkg::OFF_IPR, 32'h0000_0000);
    cfg(11, 32'h0000_0027, 32'h0000_0B00);
    w(vpic_pkg::OFF_FFER, 32'h0000_0800);
    w(vpic_pkg::OFF_IECR, 32'h0000_0800);
    w(vpic_pkg::OFF_ISCR, 32'h0000_0800);
    repeat (4) @(posedge hclk);
    `CHK("forced is fast", 1'b0, fast_request_n)
    `CHK("forced not normal", 1'b1, normal_request_n)
    chk_rd("vector forced", vpic_pkg::OFF_IVR, 32'h0000_0000);
    chk_rd("forced kept", vpic_pkg::OFF_IPR, 32'h0000_0800);
    w(vpic_pkg::OFF_ICCR, 32'h0000_0800);
    w(vpic_pkg::OFF_FFDR, 32'h0000_0800);
    w(vpic_pkg::OFF_IDCR, 32'hFFFF_FFFF);
    $display("t_fast finished");
  endtask

  task t_pins;
    cfg(31, 32'h0000_0040, 32'h0000_0000);
    repeat (6) @(posedge hclk);
    chk_rd("pin high level", vpic_pkg::OFF_IPR, 32'h8000_0000);
    irq_src[31] <= 1'b0;
    cfg(30, 32'h0000_0020, 32'h0000_0000);
    irq_src[30] <= 1'b0;
    repeat (6) @(posedge hclk);
    chk_rd("pin falling edge", vpic_pkg::OFF_IPR, 32'h4000_0000);
    irq_src[30] <= 1'b1;
    w(vpic_pkg::OFF_ICCR, 32'h4000_0000);
    repeat (6) @(posedge hclk);
    chk_rd("pins quiet", vpic_pkg::OFF_IPR, 32'h0000_0000);
    irq_src[0] <= 1'b0;
    irq_src[30] <= 1'b0;
    cfg(30, 32'h0000_0000, 32'h0000_0000);
    repeat (6) @(posedge hclk);
    irq_src[0] <= 1'b1;
    repeat (6) @(posedge hclk);
    chk_rd("pin rising and low level", vpic_pkg::OFF_IPR, 32'h4000_0001);
    $display("t_pins finished");
  endtask

  initial begin
    hresetn = 1'b0;
    // External pins idle high so the low-level reset mode sees no activity
    irq_src = vpic_pkg::EXT_MASK;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_mask;
    t_cmds;
    t_prio;
    t_nest;
    t_fast;
    t_pins;
    close_out;
  end
endmodule

`default_nettype wire

// file: tb/vpic_core_model.sv
`timescale 1ns/100ps
`default_nettype none

// Processor side of the block: a single-transfer bus master
module vpic_core_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // Called just after a rising edge; returns at the edge that took the data
  task automatic xfer(input logic wr, input logic [8:0] off, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= vpic_pkg::BASE_ADDR + {23'h000000, off};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // Released data lines must not keep showing the last word
    hwdata <= ~wd;
  endtask

  // Each serviced vector read is closed by one end-of-interrupt write
  task automatic eoi;
    logic [31:0] dummy;
    xfer(1'b1, vpic_pkg::OFF_EOICR, 32'h0000_0000, dummy);
  endtask
endmodule

`default_nettype wire
